// ===== pec_params.svh
`ifndef PEC_PARAMS_SVH
`define PEC_PARAMS_SVH

// Sizes of the counter bank
`define PEC_NUM_CNT 4
`define PEC_CNT_W 32
`define PEC_EVT_W 8
`define PEC_CSEL_W 2
`define PEC_INC_W 2
`define PEC_OVF_W 5

// Reset values
`define PEC_CNT_RST 32'h0000_0000
`define PEC_EVT_RST 8'h00
`define PEC_CSEL_RST 2'h0

// Event codes
`define PEC_EV_WBUF_FULL 8'h40
`define PEC_EV_L2_MERGE 8'h41
`define PEC_EV_L2_BUF_ST 8'h42
`define PEC_EV_L2_ACCESS 8'h43
`define PEC_EV_L2_MISS 8'h44
`define PEC_EV_BUS_RD 8'h45
`define PEC_EV_BUS_WR 8'h46
`define PEC_EV_REPLAY 8'h47
`define PEC_EV_UNAL_REPLAY 8'h48
`define PEC_EV_L1D_HASH 8'h49
`define PEC_EV_L1I_HASH 8'h4A
`define PEC_EV_L1D_ALIAS 8'h4B
`define PEC_EV_SIMD_L1D_HIT 8'h4C
`define PEC_EV_SIMD_L1D_ACC 8'h4D
`define PEC_EV_SIMD_L2_ACC 8'h4E
`define PEC_EV_SIMD_L2_HIT 8'h4F
`define PEC_EV_L1I_ACCESS 8'h50
`define PEC_EV_RET_MISP 8'h51
`define PEC_EV_BR_DIR_MISP 8'h52
`define PEC_EV_BR_PRED_TK 8'h53
`define PEC_EV_BR_EXEC_TK 8'h54
`define PEC_EV_OPS_ISSUED 8'h55
`define PEC_EV_ISSUE_EMPTY 8'h56
`define PEC_EV_INST_ISSUED 8'h57
`define PEC_EV_SIMD_XFER 8'h58
`define PEC_EV_SIMD_QFULL 8'h59
`define PEC_EV_BOTH_BUSY 8'h5A
`define PEC_EV_EXT0 8'h70
`define PEC_EV_EXT1 8'h71
`define PEC_EV_EXT_BOTH 8'h72

`endif

// ===== pec_pkg.sv
package pec_pkg;

  // Register chosen by a coprocessor access
  typedef enum logic [1:0] {
    PEC_REG_CSEL = 2'b00,
    PEC_REG_ESEL = 2'b01,
    PEC_REG_COUNT = 2'b10
  } pec_reg_t;

  // One access from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic user;
    pec_reg_t reg_id;
    logic [31:0] wdata;
  } pec_cp_req_t;

  // Answer, one cycle after the access
  typedef struct packed {
    logic [31:0] rdata;
    logic ack;
    logic undef;
  } pec_cp_rsp_t;

  // Raw event pulses from pipeline, caches and memory system
  typedef struct packed {
    logic wbuf_full;
    logic l2_store_merge;
    logic l2_store;
    logic l2_store_castout;
    logic l2_access;
    logic l2_miss;
    logic bus_rd_xfer;
    logic bus_wr_xfer;
    logic replay;
    logic unaligned_replay;
    logic l1d_lookup;
    logic l1d_hash_hit;
    logic l1d_phys_hit;
    logic l1d_same_way;
    logic l1d_va12;
    logic l1d_pa12;
    logic l1i_lookup;
    logic l1i_hash_hit;
    logic l1i_phys_hit;
    logic l1i_same_way;
    logic l1i_by_sysctl;
    logic simd_l1d_hit;
    logic simd_l1d_access;
    logic simd_l2_access;
    logic simd_l2_hit;
    logic ret_mispredict;
    logic br_resolve;
    logic br_pred_taken;
    logic br_taken;
    logic br_predictable;
    logic [1:0] ops_issued;
    logic issue_empty;
    logic [1:0] insts_issued;
    logic simd_xfer_stall;
    logic simd_queue_stall;
    logic simd_busy;
    logic core_busy;
  } pec_events_t;

endpackage : pec_pkg

// ===== pec_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "pec_params.svh"

module pec_counter (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Control
  input wire logic [`PEC_INC_W-1:0] i_inc,
  input wire logic i_cnt_we,
  input wire logic i_evt_we,
  input wire logic [`PEC_CNT_W-1:0] i_wdata,
  input wire logic i_ovf_clr,
  // State
  output logic [`PEC_CNT_W-1:0] o_count,
  output logic [`PEC_EVT_W-1:0] o_event,
  output logic o_ovf
);

  logic [`PEC_CNT_W-1:0] cnt_r;
  logic [`PEC_CNT_W-1:0] cnt_nxt;
  logic [`PEC_EVT_W-1:0] evt_r;
  logic [`PEC_EVT_W-1:0] evt_nxt;
  logic ovf_r;
  logic ovf_nxt;
  logic [`PEC_CNT_W:0] sum;
  logic wrap;

  // Software write beats a same-cycle increment
  assign sum = {1'b0, cnt_r} + {{(`PEC_CNT_W-1){1'b0}}, i_inc};
  assign wrap = ~i_cnt_we & sum[`PEC_CNT_W];
  assign cnt_nxt = i_cnt_we ? i_wdata : sum[`PEC_CNT_W-1:0];
  assign evt_nxt = i_evt_we ? i_wdata[`PEC_EVT_W-1:0] : evt_r;
  // A wrap in the clearing cycle keeps the flag set
  assign ovf_nxt = wrap | (ovf_r & ~i_ovf_clr);

  // Count, event code and overflow flag
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= `PEC_CNT_RST;
      evt_r <= `PEC_EVT_RST;
      ovf_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      evt_r <= evt_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  assign o_count = cnt_r;
  assign o_event = evt_r;
  assign o_ovf = ovf_r;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  AST_CNT_WRAP: assert property (
    (&cnt_r && i_inc != 2'h0 && !i_cnt_we) |=>
      (ovf_r && cnt_r < 32'h0000_0002))
    else $error("counter did not wrap into overflow");

  AST_CNT_WRITE: assert property (
    i_cnt_we |=> cnt_r == $past(i_wdata))
    else $error("count write lost");

endmodule : pec_counter
`default_nettype wire

// ===== pec_top.sv
// How it works
// - Code 0x40 counts every cycle the write buffer is full.
// - Code 0x41 counts stores merged in the level-two memory system.
// - Code 0x42 counts bufferable stores to level two, not cast-outs.
// - Code 0x43 counts level-two accesses, 0x44 cacheable level-two misses.
// - Codes 0x45 and 0x46 count bus read and write data transfers.
// - Code 0x47 counts all replays, 0x48 unaligned accesses that replay.
// - Code 0x49 counts level-one data misses caused by the hash.
// - Code 0x4A counts level-one instruction misses caused by the hash.
// - Code 0x4B counts data accesses where VA and PA bit 12 differ.
// - Codes 0x4C to 0x4F count SIMD cache hits and accesses.
// - Code 0x50 counts instruction cache accesses, not coprocessor ones.
// - Code 0x51 counts wrong-target return stack pops.
// - Code 0x52 counts branch direction mispredictions both ways.
// - Code 0x53 counts predicted-taken branches, 0x54 executed-taken ones.
// - Code 0x55 adds the operations issued.
// - Code 0x56 counts cycles with nothing available to issue.
// - Code 0x57 adds instructions issued per cycle, multi-cycle once.
// - Codes 0x58 and 0x59 count SIMD transfer and queue stall cycles.
// - Code 0x5A counts cycles where SIMD and core are both busy.
// - Codes 0x70, 0x71, 0x72 count external inputs 0, 1 and both.
// - Interrupt is shown only on the active-low interrupt pin.
// - Four counters; select register picks one, event select sets its code.
// - Each counter and the cycle counter have their own interrupt enable.
// - User accesses are undefined unless user enable is set.
`timescale 1ns/100ps
`default_nettype none
`include "pec_params.svh"

module pec_top (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Coprocessor register access
  input wire pec_pkg::pec_cp_req_t i_cp_req,
  input wire logic i_user_en,
  output pec_pkg::pec_cp_rsp_t o_cp_rsp,
  // Event sources
  input wire pec_pkg::pec_events_t i_events,
  input wire logic [1:0] i_external_event_in,
  // Overflow and interrupt
  input wire logic [`PEC_OVF_W-1:0] i_ovf_irq_en,
  input wire logic [`PEC_OVF_W-1:0] i_ovf_clr,
  output logic [`PEC_OVF_W-1:0] o_ovf_flags,
  output logic o_monitor_irq_n
);

  // Decoded event terms
  logic l1d_hash_miss;
  logic l1i_hash_miss;
  logic l1d_alias;
  logic l2_buf_store;
  logic l1i_access;
  logic br_dir_misp;
  logic br_pred_tk;
  logic br_exec_tk;
  logic both_busy;

  // Access decode
  logic access_ok;
  logic access_undef;
  logic wr_csel;
  logic wr_esel;
  logic wr_count;

  // Register state
  logic [`PEC_CSEL_W-1:0] csel_r;
  logic [`PEC_CSEL_W-1:0] csel_nxt;
  pec_pkg::pec_cp_rsp_t rsp_r;
  pec_pkg::pec_cp_rsp_t rsp_nxt;
  logic [31:0] rdata_sel;
  logic [`PEC_CNT_W-1:0] cyc_r;
  logic cyc_ovf_r;
  logic cyc_ovf_nxt;
  logic irq_n_r;
  logic irq_pend;

  // Counter bank
  logic [`PEC_CNT_W-1:0] count [`PEC_NUM_CNT];
  logic [`PEC_EVT_W-1:0] evt [`PEC_NUM_CNT];
  logic [`PEC_NUM_CNT-1:0] cnt_ovf;
  logic [`PEC_OVF_W-1:0] ovf_all;

  // Hash misses: hash hit with physical miss, hit in another way,
  // or hash miss with physical hit
  assign l1d_hash_miss = i_events.l1d_lookup & (
    (i_events.l1d_hash_hit & ~i_events.l1d_phys_hit) |
    (i_events.l1d_hash_hit & ~i_events.l1d_same_way) |
    (~i_events.l1d_hash_hit & i_events.l1d_phys_hit));
  assign l1i_hash_miss = i_events.l1i_lookup & (
    (i_events.l1i_hash_hit & ~i_events.l1i_phys_hit) |
    (i_events.l1i_hash_hit & ~i_events.l1i_same_way) |
    (~i_events.l1i_hash_hit & i_events.l1i_phys_hit));
  // Page colour alias on bit 12
  assign l1d_alias = i_events.l1d_lookup &
    (i_events.l1d_va12 ^ i_events.l1d_pa12);
  // Cast-out data is filtered here, not trusted to the source
  assign l2_buf_store = i_events.l2_store &
    ~i_events.l2_store_castout;
  assign l1i_access = i_events.l1i_lookup &
    ~i_events.l1i_by_sysctl;
  // Misprediction in either direction
  assign br_dir_misp = i_events.br_resolve &
    (i_events.br_pred_taken ^ i_events.br_taken);
  assign br_pred_tk = i_events.br_resolve & i_events.br_predictable &
    i_events.br_pred_taken;
  assign br_exec_tk = i_events.br_resolve & i_events.br_predictable &
    i_events.br_taken;
  assign both_busy = i_events.simd_busy & i_events.core_busy;

  // Amount to add for one event code
  function automatic logic [`PEC_INC_W-1:0] evt_amount(
    input logic [`PEC_EVT_W-1:0] code
  );
    logic [`PEC_INC_W-1:0] amt;
    amt = 2'h0;
    case (code)
      `PEC_EV_WBUF_FULL: amt = {1'b0, i_events.wbuf_full};
      `PEC_EV_L2_MERGE: amt = {1'b0, i_events.l2_store_merge};
      `PEC_EV_L2_BUF_ST: amt = {1'b0, l2_buf_store};
      `PEC_EV_L2_ACCESS: amt = {1'b0, i_events.l2_access};
      `PEC_EV_L2_MISS: amt = {1'b0, i_events.l2_miss};
      `PEC_EV_BUS_RD: amt = {1'b0, i_events.bus_rd_xfer};
      `PEC_EV_BUS_WR: amt = {1'b0, i_events.bus_wr_xfer};
      `PEC_EV_REPLAY: amt = {1'b0, i_events.replay};
      `PEC_EV_UNAL_REPLAY: amt = {1'b0, i_events.unaligned_replay};
      `PEC_EV_L1D_HASH: amt = {1'b0, l1d_hash_miss};
      `PEC_EV_L1I_HASH: amt = {1'b0, l1i_hash_miss};
      `PEC_EV_L1D_ALIAS: amt = {1'b0, l1d_alias};
      `PEC_EV_SIMD_L1D_HIT: amt = {1'b0, i_events.simd_l1d_hit};
      `PEC_EV_SIMD_L1D_ACC: amt = {1'b0, i_events.simd_l1d_access};
      `PEC_EV_SIMD_L2_ACC: amt = {1'b0, i_events.simd_l2_access};
      `PEC_EV_SIMD_L2_HIT: amt = {1'b0, i_events.simd_l2_hit};
      `PEC_EV_L1I_ACCESS: amt = {1'b0, l1i_access};
      `PEC_EV_RET_MISP: amt = {1'b0, i_events.ret_mispredict};
      `PEC_EV_BR_DIR_MISP: amt = {1'b0, br_dir_misp};
      `PEC_EV_BR_PRED_TK: amt = {1'b0, br_pred_tk};
      `PEC_EV_BR_EXEC_TK: amt = {1'b0, br_exec_tk};
      `PEC_EV_OPS_ISSUED: amt = i_events.ops_issued;
      `PEC_EV_ISSUE_EMPTY: amt = {1'b0, i_events.issue_empty};
      // Source reports a multi-cycle instruction in one cycle only
      `PEC_EV_INST_ISSUED: amt = i_events.insts_issued;
      `PEC_EV_SIMD_XFER: amt = {1'b0, i_events.simd_xfer_stall};
      `PEC_EV_SIMD_QFULL: amt = {1'b0, i_events.simd_queue_stall};
      `PEC_EV_BOTH_BUSY: amt = {1'b0, both_busy};
      `PEC_EV_EXT0: amt = {1'b0, i_external_event_in[0]};
      `PEC_EV_EXT1: amt = {1'b0, i_external_event_in[1]};
      // Both inputs in one cycle add two
      `PEC_EV_EXT_BOTH: amt = {1'b0, i_external_event_in[0]} +
        {1'b0, i_external_event_in[1]};
      // Reserved and unlisted codes stay still
      default: amt = 2'h0;
    endcase
    return amt;
  endfunction : evt_amount

  // User mode is refused unless enabled; privileged always gets data
  assign access_ok = i_cp_req.valid &
    (~i_cp_req.user | i_user_en);
  assign access_undef = i_cp_req.valid & i_cp_req.user &
    ~i_user_en;
  assign wr_csel = access_ok & i_cp_req.write &
    (i_cp_req.reg_id == pec_pkg::PEC_REG_CSEL);
  assign wr_esel = access_ok & i_cp_req.write &
    (i_cp_req.reg_id == pec_pkg::PEC_REG_ESEL);
  assign wr_count = access_ok & i_cp_req.write &
    (i_cp_req.reg_id == pec_pkg::PEC_REG_COUNT);
  assign csel_nxt = wr_csel ? i_cp_req.wdata[`PEC_CSEL_W-1:0] : csel_r;

  // The four counters, each on its own event code
  genvar g;
  generate
    for (g = 0; g < `PEC_NUM_CNT; g++) begin : g_cnt
      logic [`PEC_INC_W-1:0] inc;
      logic [`PEC_CSEL_W-1:0] idx;
      // A process, not an assign, so event pins read by the lookup wake it
      always_comb begin
        inc = evt_amount(evt[g]);
      end
      assign idx = (`PEC_CSEL_W)'(g);
      pec_counter u_cnt (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_inc(inc),
        .i_cnt_we(wr_count & (csel_r == idx)),
        .i_evt_we(wr_esel & (csel_r == idx)),
        .i_wdata(i_cp_req.wdata),
        .i_ovf_clr(i_ovf_clr[g]),
        .o_count(count[g]),
        .o_event(evt[g]),
        .o_ovf(cnt_ovf[g])
      );
    end
  endgenerate

  // Read data of the selected register; code 2'b11 reads zero
  always_comb begin
    rdata_sel = 32'h0000_0000;
    unique case (i_cp_req.reg_id)
      pec_pkg::PEC_REG_CSEL: rdata_sel = {30'h0, csel_r};
      pec_pkg::PEC_REG_ESEL: rdata_sel = {24'h0, evt[csel_r]};
      pec_pkg::PEC_REG_COUNT: rdata_sel = count[csel_r];
      default: rdata_sel = 32'h0000_0000;
    endcase
  end

  // Answer: refused accesses return zero and no side effect
  assign rsp_nxt.ack = i_cp_req.valid;
  assign rsp_nxt.undef = access_undef;
  assign rsp_nxt.rdata = (access_ok & ~i_cp_req.write) ?
    rdata_sel : 32'h0000_0000;

  // Free-running cycle counter, overflow set beats clear
  assign cyc_ovf_nxt = (&cyc_r) |
    (cyc_ovf_r & ~i_ovf_clr[`PEC_NUM_CNT]);

  // Per-source enables gate the single interrupt
  assign ovf_all = {cyc_ovf_r, cnt_ovf};
  assign irq_pend = |(ovf_all & i_ovf_irq_en);

  // Select register and response
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      csel_r <= `PEC_CSEL_RST;
      rsp_r <= '0;
    end else begin
      csel_r <= csel_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // Cycle counter and interrupt pin
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_r <= `PEC_CNT_RST;
      cyc_ovf_r <= 1'b0;
      irq_n_r <= 1'b1;
    end else begin
      cyc_r <= cyc_r + 32'h0000_0001;
      cyc_ovf_r <= cyc_ovf_nxt;
      irq_n_r <= ~irq_pend;
    end
  end

  // Outputs straight from flip-flops
  assign o_cp_rsp = rsp_r;
  assign o_monitor_irq_n = irq_n_r;
  assign o_ovf_flags = ovf_all;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // Counter k holds its code and sees no software write
  sequence s_cnt_free(int k);
    !((wr_count || wr_esel) && {30'h0, csel_r} == k);
  endsequence

  sequence s_cnt_code(int k, logic [7:0] c);
    evt[k] == c ##0 s_cnt_free(k);
  endsequence

  AST_WBUF_FULL: assert property (
    s_cnt_code(0, 8'h40) ##0 i_events.wbuf_full |=>
      count[0] == $past(count[0]) + 32'h0000_0001)
    else $error("write-buffer-full cycle not counted");

  AST_EXT_BOTH: assert property (
    s_cnt_code(1, 8'h72) ##0 (&i_external_event_in) |=>
      count[1] == $past(count[1]) + 32'h0000_0002)
    else $error("both external events not added");

  AST_CASTOUT: assert property (
    s_cnt_code(2, 8'h42) ##0 i_events.l2_store_castout |=>
      count[2] == $past(count[2]))
    else $error("cast-out store was counted");

  AST_RESERVED: assert property (
    (evt[0] inside {[8'h60:8'h6F], [8'h73:8'hFF]}) ##0 s_cnt_free(0) |=>
      $stable(count[0]))
    else $error("reserved code incremented");

  AST_USER_UNDEF: assert property (
    (i_cp_req.valid && i_cp_req.user && !i_user_en) |=>
      (o_cp_rsp.undef && o_cp_rsp.rdata == 32'h0000_0000))
    else $error("user access not refused");

  AST_PRIV_DATA: assert property (
    (i_cp_req.valid && !i_cp_req.user) |=>
      (o_cp_rsp.ack && !o_cp_rsp.undef))
    else $error("privileged access refused");

  AST_CSEL_WRITE: assert property (
    (wr_csel ##1 !wr_csel) |->
      csel_r == $past(i_cp_req.wdata[1:0]))
    else $error("counter select not taken");

  AST_IRQ_ON: assert property (
    irq_pend |=> !o_monitor_irq_n)
    else $error("enabled overflow gave no interrupt");

  AST_IRQ_OFF: assert property (
    (!irq_pend ##1 !irq_pend) |-> o_monitor_irq_n)
    else $error("interrupt without enabled overflow");

  AST_CYC_WRAP: assert property (
    (&cyc_r) |=> (cyc_r == 32'h0000_0000 && cyc_ovf_r))
    else $error("cycle counter wrap lost");

endmodule : pec_top
`default_nettype wire

// ===== pec_evt_src.sv
`timescale 1ns/100ps
`default_nettype none

module pec_evt_src (
  // Raw activity requested by the bench
  input wire pec_pkg::pec_events_t i_req,
  input wire logic [1:0] i_ext_req,
  // Event levels presented to the block
  output pec_pkg::pec_events_t o_events,
  output logic [1:0] o_external_event_in
);
  // Qualifier bits only carry meaning while their access or branch exists,
  // so a real source never shows them alone
  always_comb begin
    o_events = i_req;
    o_events.l2_store_castout = i_req.l2_store_castout & i_req.l2_store;
    o_events.l1d_hash_hit = i_req.l1d_hash_hit & i_req.l1d_lookup;
    o_events.l1d_phys_hit = i_req.l1d_phys_hit & i_req.l1d_lookup;
    o_events.l1d_same_way = i_req.l1d_same_way & i_req.l1d_lookup;
    o_events.l1d_va12 = i_req.l1d_va12 & i_req.l1d_lookup;
    o_events.l1d_pa12 = i_req.l1d_pa12 & i_req.l1d_lookup;
    o_events.l1i_hash_hit = i_req.l1i_hash_hit & i_req.l1i_lookup;
    o_events.l1i_phys_hit = i_req.l1i_phys_hit & i_req.l1i_lookup;
    o_events.l1i_same_way = i_req.l1i_same_way & i_req.l1i_lookup;
    o_events.l1i_by_sysctl = i_req.l1i_by_sysctl & i_req.l1i_lookup;
    o_events.br_pred_taken = i_req.br_pred_taken & i_req.br_resolve;
    o_events.br_taken = i_req.br_taken & i_req.br_resolve;
    o_events.br_predictable = i_req.br_resolve;
  end

  // External inputs are plain levels from outside logic
  assign o_external_event_in = i_ext_req;
endmodule : pec_evt_src

`default_nettype wire

// ===== perf_event_counters_bench.sv
`timescale 1ns/100ps
`default_nettype none

module perf_event_counters_bench;
  localparam int MAX_CYCLES = 10000;
  localparam logic [7:0] EXTRA [10] = '{8'h70, 8'h71, 8'h72, 8'h00, 8'h3F,
                                        8'h5B, 8'h60, 8'h6F, 8'h73, 8'hFF};
  // Port signals
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  pec_pkg::pec_cp_req_t cp_req = '0;
  pec_pkg::pec_cp_rsp_t cp_rsp;
  pec_pkg::pec_events_t ev_req = '0;
  pec_pkg::pec_events_t events;
  logic [1:0] ext_req = 2'h0;
  logic [1:0] ext_in;
  logic user_en = 1'b0;
  logic [4:0] irq_en = 5'h00;
  logic [4:0] ovf_clr = 5'h00;
  logic [4:0] ovf_flags;
  logic irq_n;
  // Reference state
  logic [31:0] exp_cnt [4] = '{32'h0, 32'h0, 32'h0, 32'h0};
  logic [7:0] exp_code [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [4:0] exp_flag = 5'h00;
  logic [1:0] exp_csel = 2'h0;
  logic [31:0] seed = 32'h0000_9194;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  pec_top i_pec_top (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_cp_req(cp_req), .i_user_en(user_en), .o_cp_rsp(cp_rsp),
    .i_events(events), .i_external_event_in(ext_in),
    .i_ovf_irq_en(irq_en), .i_ovf_clr(ovf_clr),
    .o_ovf_flags(ovf_flags), .o_monitor_irq_n(irq_n));

  pec_evt_src i_pec_evt_src (.i_req(ev_req), .i_ext_req(ext_req),
    .o_events(events), .o_external_event_in(ext_in));

  // Repeatable random source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Amount one cycle of activity adds under a given code
  function automatic logic [1:0] inc_of(input logic [7:0] c,
    input pec_pkg::pec_events_t e, input logic [1:0] x);
    case (c)
      8'h40: return {1'b0, e.wbuf_full};
      8'h41: return {1'b0, e.l2_store_merge};
      8'h42: return {1'b0, e.l2_store & ~e.l2_store_castout};
      8'h43: return {1'b0, e.l2_access};
      8'h44: return {1'b0, e.l2_miss};
      8'h45: return {1'b0, e.bus_rd_xfer};
      8'h46: return {1'b0, e.bus_wr_xfer};
      8'h47: return {1'b0, e.replay};
      8'h48: return {1'b0, e.unaligned_replay};
      8'h49: return {1'b0, e.l1d_lookup & ((e.l1d_hash_hit &
        ~(e.l1d_phys_hit & e.l1d_same_way)) |
        (~e.l1d_hash_hit & e.l1d_phys_hit))};
      8'h4A: return {1'b0, e.l1i_lookup & ((e.l1i_hash_hit &
        ~(e.l1i_phys_hit & e.l1i_same_way)) |
        (~e.l1i_hash_hit & e.l1i_phys_hit))};
      8'h4B: return {1'b0, e.l1d_lookup & (e.l1d_va12 ^ e.l1d_pa12)};
      8'h4C: return {1'b0, e.simd_l1d_hit};
      8'h4D: return {1'b0, e.simd_l1d_access};
      8'h4E: return {1'b0, e.simd_l2_access};
      8'h4F: return {1'b0, e.simd_l2_hit};
      8'h50: return {1'b0, e.l1i_lookup & ~e.l1i_by_sysctl};
      8'h51: return {1'b0, e.ret_mispredict};
      8'h52: return {1'b0, e.br_resolve & (e.br_pred_taken ^ e.br_taken)};
      8'h53: return {1'b0, e.br_predictable & e.br_pred_taken};
      8'h54: return {1'b0, e.br_predictable & e.br_taken};
      8'h55: return e.ops_issued;
      8'h56: return {1'b0, e.issue_empty};
      8'h57: return e.insts_issued;
      8'h58: return {1'b0, e.simd_xfer_stall};
      8'h59: return {1'b0, e.simd_queue_stall};
      8'h5A: return {1'b0, e.simd_busy & e.core_busy};
      8'h70: return {1'b0, x[0]};
      8'h71: return {1'b0, x[1]};
      8'h72: return {1'b0, x[0]} + {1'b0, x[1]};
      default: return 2'h0;
    endcase
  endfunction : inc_of

  // Reference counters advance on the same edge as the block
  always @(posedge clk_sys) begin : ref_model
    logic [32:0] sum;
    if (rst_n) begin
      exp_flag = exp_flag & ~ovf_clr;
      for (int k = 0; k < 4; k++) begin
        sum = {1'b0, exp_cnt[k]} +
          {31'h0, inc_of(exp_code[k], events, ext_in)};
        exp_cnt[k] = sum[31:0];
        exp_flag[k] = exp_flag[k] | sum[32];
      end
    end
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == MAX_CYCLES) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One access: strobe for one cycle, then wait a bounded time for ack
  task automatic cp(input logic wr, input logic usr, input logic [1:0] rid,
    input logic [31:0] wd, output logic [31:0] rd, output logic und);
    int n;
    @(negedge clk_sys);
    cp_req = '{valid: 1'b1, write: wr, user: usr,
      reg_id: pec_pkg::pec_reg_t'(rid), wdata: wd};
    @(negedge clk_sys);
    cp_req.valid = 1'b0;
    n = 0;
    while (cp_rsp.ack !== 1'b1 && n < 3) begin
      @(negedge clk_sys);
      n++;
    end
    chk("ack", 32'h1, {31'h0, cp_rsp.ack});
    rd = cp_rsp.rdata;
    und = cp_rsp.undef;
  endtask : cp

  task automatic wr(input logic [1:0] rid, input logic [31:0] wd);
    logic [31:0] r;
    logic u;
    cp(1'b1, 1'b0, rid, wd, r, u);
    chk("write undef", 32'h0, {31'h0, u});
    if (rid == 2'h0) exp_csel = wd[1:0];
    if (rid == 2'h1) exp_code[exp_csel] = wd[7:0];
    if (rid == 2'h2) exp_cnt[exp_csel] = wd;
  endtask : wr

  task automatic rdc(input logic [1:0] rid, input logic [31:0] exp,
    input string name);
    logic [31:0] r;
    logic u;
    cp(1'b0, 1'b0, rid, 32'h0, r, u);
    chk(name, exp, r);
  endtask : rdc

  // One code on one counter, started near all ones so wraps occur
  task automatic run(input int i, input logic [7:0] code);
    logic [63:0] s;
    wr(2'h0, 32'(i % 4));
    rdc(2'h0, 32'(i % 4), "select");
    rdc(2'h2, exp_cnt[exp_csel], "held count");
    wr(2'h1, {24'h0, code});
    rdc(2'h1, {24'h0, code}, "event code");
    s = {xs(), xs()};
    wr(2'h2, {28'hFFFFFFF, s[3:0]});
    irq_en = s[8:4];
    repeat (24) begin
      @(negedge clk_sys);
      s = {xs(), xs()};
      ev_req = s[38:0];
      ext_req = s[40:39];
    end
    @(negedge clk_sys);
    ev_req = '0;
    ext_req = 2'h0;
    rdc(2'h2, exp_cnt[exp_csel], "count");
    chk("flags", {27'h0, exp_flag}, {27'h0, ovf_flags});
    chk("irq", {31'h0, ~|(exp_flag & irq_en)}, {31'h0, irq_n});
    ovf_clr = 5'h1F;
    @(negedge clk_sys);
    ovf_clr = 5'h00;
    repeat (2) @(negedge clk_sys);
    chk("cleared", 32'h0, {27'h0, ovf_flags});
    chk("irq idle", 32'h1, {31'h0, irq_n});
  endtask : run

  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // Main sequence
  initial begin : main
    logic [31:0] r;
    logic u;
    repeat (3) @(negedge clk_sys);
    chk("reset rsp", 32'h0, {30'h0, cp_rsp.ack, cp_rsp.undef});
    chk("reset flags", 32'h0, {27'h0, ovf_flags});
    chk("reset irq", 32'h1, {31'h0, irq_n});
    rst_n = 1'b1;
    rdc(2'h2, 32'h0, "reset count");
    rdc(2'h1, 32'h0, "reset code");
    for (int i = 0; i < 37; i++) begin
      run(i, (i < 27) ? 8'h40 + 8'(i) : EXTRA[i - 27]);
    end
    cp(1'b1, 1'b1, 2'h2, 32'h0000_1234, r, u);
    chk("user write undef", 32'h1, {31'h0, u});
    rdc(2'h2, exp_cnt[exp_csel], "refused write");
    cp(1'b0, 1'b1, 2'h2, 32'h0, r, u);
    chk("user read undef", 32'h1, {31'h0, u});
    chk("user read data", 32'h0, r);
    user_en = 1'b1;
    cp(1'b0, 1'b1, 2'h2, 32'h0, r, u);
    chk("enabled undef", 32'h0, {31'h0, u});
    chk("enabled data", exp_cnt[exp_csel], r);
    cp(1'b0, 1'b0, 2'h3, 32'h0, r, u);
    chk("unmapped", 32'h0, r);
    close_out();
  end
endmodule : perf_event_counters_bench

`default_nettype wire
